// [core/snic_cfg.svh]
// Purpose: Constants of the serial network interface card and its poll master.
// Assumes: 125 MHz system clock.
// Notes:   Byte offsets on the APB side; times in ms with derived cycle counts.
`ifndef SNIC_CFG_SVH
`define SNIC_CFG_SVH

`define SNIC_CLK_KHZ     125000
`define SNIC_OSC_KHZ     28800
`define SNIC_OSC_NUM     (`SNIC_OSC_KHZ / 100)
`define SNIC_OSC_DEN     (`SNIC_CLK_KHZ / 100)
`define SNIC_CYCLE_MS    32
`define SNIC_DEAD_MS     4
`define SNIC_WDOG_MS     64
`define SNIC_CYCLE_CLKS  (`SNIC_CYCLE_MS * `SNIC_CLK_KHZ)
`define SNIC_DEAD_CLKS   (`SNIC_DEAD_MS * `SNIC_CLK_KHZ)
`define SNIC_WDOG_CLKS   (`SNIC_WDOG_MS * `SNIC_CLK_KHZ)
`define SNIC_OVS         16
`define SNIC_HALF_BIT    8
`define SNIC_DATA_BITS   16
`define SNIC_PKT_BITS    18
`define SNIC_TAGS        8

`define SNIC_OFS_CTRL    12'h000
`define SNIC_OFS_STAT    12'h004
`define SNIC_OFS_IDENT   12'h008
`define SNIC_OFS_CFG     12'h00C
`define SNIC_OFS_RAM     12'h100
`define SNIC_OFS_TAG     12'h200
`define SNIC_MASK_RAM    12'hF80
`define SNIC_MASK_TAG    12'hFE0

`define SNIC_CTRL_HANDOVER 0
`define SNIC_CTRL_CHIPRST  1
`define SNIC_CFG_LOCK_RST  1'b1

`endif

// [core/snic_pkg.sv]
// Purpose: Types and shared arithmetic of the network interface card.
// Assumes: Constants come from snic_cfg.svh.
// Notes:   osc_next is the 28.8 MHz fractional divider step.
`include "snic_cfg.svh"
package snic_pkg;

  typedef enum logic [2:0] {
    AL_HUNT = 3'b001,
    AL_MID  = 3'b010,
    AL_BITS = 3'b100
  } snic_al_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SCAN = 3'b010,
    TX_SEND = 3'b100
  } snic_tx_e;

  typedef enum logic [1:0] {
    MT_IDLE = 2'b01,
    MT_SEND = 2'b10
  } snic_mtx_e;

  // Bit 11 is the oscillator tick, bits 10:0 the new phase
  function automatic logic [11:0] osc_next(input logic [10:0] acc);
    logic [10:0] sum;
    sum = acc + 11'(`SNIC_OSC_NUM);
    if (sum >= 11'(`SNIC_OSC_DEN)) begin
      return {1'b1, sum - 11'(`SNIC_OSC_DEN)};
    end
    return {1'b0, sum};
  endfunction

endpackage

// [core/snic_if.sv]
// Purpose: Four-wire network link between poll master and interface card.
// Assumes: Line and priority wire idle high, pulled up.
// Notes:   Wire levels are resolved here from the output enables.
`timescale 1ns/10ps
interface snic_if;
  logic sync;
  logic downstream;
  logic m_line_o;
  logic m_line_oe;
  logic c_line_o;
  logic c_line_oe;
  logic c_pri_o;
  logic c_pri_oe;
  wire  line = m_line_oe ? m_line_o : (c_line_oe ? c_line_o : 1'b1);
  wire  pri  = c_pri_oe ? c_pri_o : 1'b1;

  modport master (output sync, downstream, m_line_o, m_line_oe, input line, pri);
  modport card   (input sync, downstream, line, pri,
                  output c_line_o, c_line_oe, c_pri_o, c_pri_oe);
endinterface

// [core/snic_bit_aligner.sv]
// Purpose: Receive sampling aligner for one network packet.
// Assumes: Line idle high; start 0, 16 bits MSB first, stop 1.
// Notes:   Sample point sits mid bit, half a bit after the start edge.
`timescale 1ns/10ps
`include "snic_cfg.svh"
module snic_bit_aligner (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_enable,
  input  wire logic       i_line,
  output logic            o_valid,
  output logic [7:0]      o_sig,
  output logic [7:0]      o_data
);
  snic_pkg::snic_al_e st_ff;
  snic_pkg::snic_al_e nxt_st;
  logic [10:0]        acc_ff;
  logic [3:0]         cnt_ff;
  logic [4:0]         bits_ff;
  logic [15:0]        shift_ff;

  wire [11:0] osc    = snic_pkg::osc_next(acc_ff);
  wire        tick   = osc[11];
  wire        mid_ok = tick & (cnt_ff == 4'(`SNIC_HALF_BIT - 1));
  wire        bit_ok = tick & (cnt_ff == 4'(`SNIC_OVS - 1));
  wire        last   = bits_ff == 5'(`SNIC_DATA_BITS);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      snic_pkg::AL_HUNT: if (!i_line) nxt_st = snic_pkg::AL_MID;
      snic_pkg::AL_MID:  if (mid_ok) nxt_st = i_line ? snic_pkg::AL_HUNT : snic_pkg::AL_BITS;
      snic_pkg::AL_BITS: if (bit_ok && last) nxt_st = snic_pkg::AL_HUNT;
    endcase
    if (!i_enable) nxt_st = snic_pkg::AL_HUNT;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_ff    <= snic_pkg::AL_HUNT;
      acc_ff   <= 11'h000;
      cnt_ff   <= 4'h0;
      bits_ff  <= 5'h00;
      shift_ff <= 16'h0000;
      o_valid  <= 1'b0;
      o_sig    <= 8'h00;
      o_data   <= 8'h00;
    end else begin
      st_ff   <= nxt_st;
      acc_ff  <= osc[10:0];
      o_valid <= 1'b0;
      if (st_ff != nxt_st) begin
        cnt_ff  <= 4'h0;
        bits_ff <= 5'h00;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      // Sample at the middle of each data bit, where it is stable
      if (st_ff == snic_pkg::AL_BITS && bit_ok && !last) begin
        shift_ff <= {shift_ff[14:0], i_line};
        bits_ff  <= bits_ff + 5'h01;
      end
      if (st_ff == snic_pkg::AL_BITS && bit_ok && last && i_line && i_enable) begin
        o_valid <= 1'b1;
        o_sig   <= shift_ff[15:8];
        o_data  <= shift_ff[7:0];
      end
    end
  end
endmodule

// [core/snic_card.sv]
// Purpose: Device end: network interface card with APB register access.
// Assumes: One 125 MHz clock; link pins synchronous to it.
// Notes:   The chip engine runs while it owns control and is out of reset.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`include "snic_cfg.svh"
module snic_card #(
  parameter int unsigned CYCLE_CLKS = `SNIC_CYCLE_CLKS,
  parameter int unsigned DEAD_CLKS  = `SNIC_DEAD_CLKS,
  parameter int unsigned WDOG_CLKS  = `SNIC_WDOG_CLKS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_frame_tick,
  output logic             o_relay_close,
  output logic             o_autopoll,
  snic_if.card             net
);
  logic [15:0]        pkt_ram [0:31];
  logic [8:0]         tag_ram [0:`SNIC_TAGS-1];
  logic [1:0]         latch_ff;
  logic [7:0]         ident_ff;
  logic               lock_ff;
  logic [31:0]        frame_cnt_ff;
  logic               sync_d_ff;
  logic               mark_d_ff;
  logic [31:0]        wdog_cnt_ff;
  logic               autopoll_ff;
  logic [4:0]         rx_ptr_ff;
  snic_pkg::snic_tx_e tx_st_ff;
  snic_pkg::snic_tx_e nxt_tx_st;
  logic [4:0]         tx_idx_ff;
  logic [17:0]        tx_shift_ff;
  logic [4:0]         tx_bit_ff;
  logic [3:0]         tx_tick_ff;
  logic [10:0]        tx_acc_ff;
  logic               tx_oe_ff;
  logic               tx_pend_ff;
  logic               pri_oe_ff;
  logic               tag_hit;
  logic               al_valid;
  logic [7:0]         al_sig;
  logic [7:0]         al_data;

  // Cycle timing
  wire marker     = frame_cnt_ff >= DEAD_CLKS;
  wire dead       = ~net.sync & ~marker;
  wire sync_rise  = net.sync & ~sync_d_ff;
  wire xfer_start = marker & ~mark_d_ff;
  wire chip_run   = latch_ff[`SNIC_CTRL_HANDOVER] & ~latch_ff[`SNIC_CTRL_CHIPRST];

  wire [31:0] nxt_frame_cnt =
    (lock_ff & ~autopoll_ff & sync_rise) ? DEAD_CLKS :
    (frame_cnt_ff == CYCLE_CLKS - 1)     ? 32'h0000_0000 :
                                           frame_cnt_ff + 32'h0000_0001;

  // Receive path
  snic_bit_aligner u_aligner (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_enable  (chip_run),
    .i_line    (net.line),
    .o_valid   (al_valid),
    .o_sig     (al_sig),
    .o_data    (al_data)
  );

  always_comb begin
    tag_hit = 1'b0;
    for (int i = 0; i < `SNIC_TAGS; i++) begin
      if (tag_ram[i][8] && tag_ram[i][7:0] == al_sig) tag_hit = 1'b1;
    end
  end

  wire poll_hit = al_valid & chip_run & ~autopoll_ff & (al_sig == ident_ff);
  wire rx_store = al_valid & chip_run & ~poll_hit & tag_hit & ~rx_ptr_ff[4];
  wire tx_start = chip_run & marker & (poll_hit | (autopoll_ff & xfer_start));

  // APB decode; a host access yields one cycle to a chip RAM write
  wire take    = i_psel & ~o_pready & ~rx_store;
  wire hit_ram = (i_paddr & `SNIC_MASK_RAM) == `SNIC_OFS_RAM;
  wire hit_tag = (i_paddr & `SNIC_MASK_TAG) == `SNIC_OFS_TAG;
  wire ram_ok  = dead & ~latch_ff[`SNIC_CTRL_HANDOVER];
  wire hit_reg = (i_paddr == `SNIC_OFS_CTRL) | (i_paddr == `SNIC_OFS_STAT) |
                 (i_paddr == `SNIC_OFS_IDENT) | (i_paddr == `SNIC_OFS_CFG);
  wire err     = ~(hit_reg | hit_tag | (hit_ram & ram_ok));
  wire wr      = take & i_pwrite & ~err;

  wire [31:0] stat_word = {19'h0_0000, rx_ptr_ff, 3'h0, autopoll_ff, o_relay_close,
                           dead, marker, net.sync};
  wire [31:0] rd_word =
    (i_paddr == `SNIC_OFS_STAT)  ? stat_word :
    (i_paddr == `SNIC_OFS_IDENT) ? {24'h00_0000, ident_ff} :
    (i_paddr == `SNIC_OFS_CFG)   ? {31'h0000_0000, lock_ff} :
    (hit_ram & ram_ok)           ? {16'h0000, pkt_ram[i_paddr[6:2]]} :
    hit_tag                      ? {23'h00_0000, tag_ram[i_paddr[4:2]]} :
                                   32'h0000_0000;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= take;
      o_prdata  <= (take & ~i_pwrite & ~err) ? rd_word : 32'h0000_0000;
      o_pslverr <= take & err;
    end
  end

  // Registers; latch bits hold until rewritten or reset
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      latch_ff <= 2'h0;
      ident_ff <= 8'h00;
      lock_ff  <= `SNIC_CFG_LOCK_RST;
      for (int i = 0; i < `SNIC_TAGS; i++) tag_ram[i] <= 9'h000;
    end else if (wr) begin
      if (i_paddr == `SNIC_OFS_CTRL) latch_ff <= i_pwdata[1:0];
      if (i_paddr == `SNIC_OFS_IDENT) ident_ff <= i_pwdata[7:0];
      if (i_paddr == `SNIC_OFS_CFG) lock_ff <= i_pwdata[0];
      if (hit_tag) tag_ram[i_paddr[4:2]] <= i_pwdata[8:0];
    end
  end

  // Lower half transmit, upper half receive
  always_ff @(posedge i_sys_clk) begin
    if (wr & hit_ram) begin
      pkt_ram[i_paddr[6:2]] <= i_pwdata[15:0];
    end else if (rx_store) begin
      pkt_ram[{1'b1, rx_ptr_ff[3:0]}] <= {al_sig, al_data};
    end
  end

  // Frame timing, watchdog, termination
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      frame_cnt_ff  <= 32'h0000_0000;
      sync_d_ff     <= 1'b0;
      mark_d_ff     <= 1'b0;
      o_frame_tick  <= 1'b0;
      wdog_cnt_ff   <= 32'h0000_0000;
      autopoll_ff   <= 1'b0;
      o_relay_close <= 1'b0;
      rx_ptr_ff     <= 5'h00;
    end else begin
      sync_d_ff     <= net.sync;
      mark_d_ff     <= marker;
      frame_cnt_ff  <= nxt_frame_cnt;
      o_frame_tick  <= nxt_frame_cnt == 32'h0000_0000;
      o_relay_close <= ~net.downstream;
      if (sync_rise) begin
        wdog_cnt_ff <= 32'h0000_0000;
        autopoll_ff <= 1'b0;
      end else if (wdog_cnt_ff == WDOG_CLKS - 1) begin
        autopoll_ff <= 1'b1;
      end else begin
        wdog_cnt_ff <= wdog_cnt_ff + 32'h0000_0001;
      end
      if (latch_ff[`SNIC_CTRL_CHIPRST] | xfer_start) begin
        rx_ptr_ff <= 5'h00;
      end else if (rx_store) begin
        rx_ptr_ff <= rx_ptr_ff + 5'h01;
      end
    end
  end

  // Transmit engine: walks the lower half, skips empty signatures
  wire [11:0] tx_osc   = snic_pkg::osc_next(tx_acc_ff);
  wire [15:0] tx_word  = pkt_ram[{1'b0, tx_idx_ff[3:0]}];
  wire        tx_bitend = tx_osc[11] & (tx_tick_ff == 4'(`SNIC_OVS - 1));
  wire        tx_last  = tx_bit_ff == 5'(`SNIC_PKT_BITS - 1);
  // Reply waits a bit after the poll's stop centre so the master has let go
  wire        tx_go    = tx_pend_ff & tx_osc[11] & (tx_tick_ff == 4'(`SNIC_OVS - 1));

  always_comb begin
    nxt_tx_st = tx_st_ff;
    unique case (tx_st_ff)
      snic_pkg::TX_IDLE: if (tx_go) nxt_tx_st = snic_pkg::TX_SCAN;
      snic_pkg::TX_SCAN: begin
        if (tx_idx_ff[4]) nxt_tx_st = snic_pkg::TX_IDLE;
        else if (tx_word[15:8] != 8'h00) nxt_tx_st = snic_pkg::TX_SEND;
      end
      snic_pkg::TX_SEND: if (tx_bitend && tx_last) nxt_tx_st = snic_pkg::TX_SCAN;
    endcase
    if (latch_ff[`SNIC_CTRL_CHIPRST]) nxt_tx_st = snic_pkg::TX_IDLE;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_st_ff    <= snic_pkg::TX_IDLE;
      tx_idx_ff   <= 5'h00;
      tx_shift_ff <= 18'h3_FFFF;
      tx_bit_ff   <= 5'h00;
      tx_tick_ff  <= 4'h0;
      tx_acc_ff   <= 11'h000;
      tx_oe_ff    <= 1'b0;
      tx_pend_ff  <= 1'b0;
      pri_oe_ff   <= 1'b0;
    end else begin
      tx_st_ff  <= nxt_tx_st;
      tx_acc_ff <= tx_osc[10:0];
      tx_oe_ff  <= nxt_tx_st == snic_pkg::TX_SEND;
      pri_oe_ff <= autopoll_ff & (nxt_tx_st == snic_pkg::TX_SEND);
      if (tx_st_ff == snic_pkg::TX_IDLE) begin
        tx_idx_ff <= 5'h00;
        if (tx_start) begin
          tx_pend_ff <= 1'b1;
          tx_tick_ff <= 4'h0;
        end else if (tx_pend_ff & tx_osc[11]) begin
          tx_tick_ff <= tx_tick_ff + 4'h1;
        end
      end else if (tx_st_ff == snic_pkg::TX_SCAN && nxt_tx_st == snic_pkg::TX_SEND) begin
        tx_shift_ff <= {1'b0, tx_word, 1'b1};
        tx_bit_ff   <= 5'h00;
        tx_tick_ff  <= 4'h0;
      end else if (tx_st_ff == snic_pkg::TX_SCAN ||
                   nxt_tx_st == snic_pkg::TX_SCAN) begin
        tx_idx_ff <= tx_idx_ff + 5'h01;
      end
      if (tx_st_ff == snic_pkg::TX_SEND && tx_osc[11]) begin
        tx_tick_ff <= tx_tick_ff + 4'h1;
        if (tx_bitend) begin
          tx_shift_ff <= {tx_shift_ff[16:0], 1'b1};
          tx_bit_ff   <= tx_bit_ff + 5'h01;
        end
      end
      if (tx_go | latch_ff[`SNIC_CTRL_CHIPRST]) begin
        tx_pend_ff <= 1'b0;
      end
    end
  end

  assign net.c_line_o  = tx_shift_ff[17];
  assign net.c_line_oe = tx_oe_ff;
  assign net.c_pri_o   = 1'b0;
  assign net.c_pri_oe  = pri_oe_ff;
  assign o_autopoll    = autopoll_ff;
endmodule

// [core/snic_poll_master.sv]
// Purpose: Far end: central poll master driving cycle sync and packets.
// Assumes: Caller sends packets only while the card is not replying.
// Notes:   Own transmissions are masked from its receiver.
`timescale 1ns/10ps
`include "snic_cfg.svh"
module snic_poll_master #(
  parameter int unsigned CYCLE_CLKS = `SNIC_CYCLE_CLKS,
  parameter int unsigned DEAD_CLKS  = `SNIC_DEAD_CLKS
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_link_up,
  input  wire logic       i_downstream_present,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_sig,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_sig,
  output logic [7:0]      o_rx_data,
  output logic            o_in_transfer,
  snic_if.master          net
);
  snic_pkg::snic_mtx_e st_ff;
  snic_pkg::snic_mtx_e nxt_st;
  logic [31:0]         cnt_ff;
  logic                down_ff;
  logic [17:0]         shift_ff;
  logic [4:0]          bit_ff;
  logic [3:0]          tick_ff;
  logic [10:0]         acc_ff;
  logic                oe_ff;

  wire [31:0] nxt_cnt  = (cnt_ff == CYCLE_CLKS - 1) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
  wire        nxt_sync = i_link_up & (nxt_cnt >= DEAD_CLKS);
  wire        accept   = i_tx_valid & o_tx_ready;
  wire [11:0] osc      = snic_pkg::osc_next(acc_ff);
  wire        bitend   = osc[11] & (tick_ff == 4'(`SNIC_OVS - 1));
  wire        rx_line  = oe_ff ? 1'b1 : net.line;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      snic_pkg::MT_IDLE: if (accept) nxt_st = snic_pkg::MT_SEND;
      snic_pkg::MT_SEND: if (bitend && bit_ff == 5'(`SNIC_PKT_BITS - 1)) nxt_st = snic_pkg::MT_IDLE;
    endcase
  end

  snic_bit_aligner u_aligner (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_enable  (i_link_up),
    .i_line    (rx_line),
    .o_valid   (o_rx_valid),
    .o_sig     (o_rx_sig),
    .o_data    (o_rx_data)
  );

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff        <= 32'h0000_0000;
      o_in_transfer <= 1'b0;
      down_ff       <= 1'b0;
      st_ff         <= snic_pkg::MT_IDLE;
      shift_ff      <= 18'h3_FFFF;
      bit_ff        <= 5'h00;
      tick_ff       <= 4'h0;
      acc_ff        <= 11'h000;
      oe_ff         <= 1'b0;
      o_tx_ready    <= 1'b0;
    end else begin
      cnt_ff        <= nxt_cnt;
      o_in_transfer <= nxt_sync;
      down_ff       <= i_downstream_present;
      st_ff         <= nxt_st;
      acc_ff        <= osc[10:0];
      oe_ff         <= nxt_st == snic_pkg::MT_SEND;
      // Packets only inside the transfer window, on an idle line
      o_tx_ready    <= (nxt_st == snic_pkg::MT_IDLE) & nxt_sync & net.line;
      if (accept) begin
        shift_ff <= {1'b0, i_tx_sig, i_tx_data, 1'b1};
        bit_ff   <= 5'h00;
        tick_ff  <= 4'h0;
      end else if (st_ff == snic_pkg::MT_SEND && osc[11]) begin
        tick_ff <= tick_ff + 4'h1;
        if (bitend) begin
          shift_ff <= {shift_ff[16:0], 1'b1};
          bit_ff   <= bit_ff + 5'h01;
        end
      end
    end
  end

  assign net.sync       = o_in_transfer;
  assign net.downstream = down_ff;
  assign net.m_line_o   = shift_ff[17];
  assign net.m_line_oe  = oe_ff;
endmodule

// [dv/snic_checker.sv]
// Purpose: Link-level assertions between the poll master and the card.
// Assumes: All link signals are sampled on the one system clock.
// Notes:   Instantiated beside the link interface; sees only its wires.
`timescale 1ns/10ps
module snic_checker #(
  parameter int unsigned CYCLE_CLKS = 8000,
  parameter int unsigned DEAD_CLKS  = 1000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic sync,
  input  wire logic downstream,
  input  wire logic m_line_o,
  input  wire logic m_line_oe,
  input  wire logic c_line_o,
  input  wire logic c_line_oe,
  input  wire logic c_pri_o,
  input  wire logic c_pri_oe,
  input  wire logic line,
  input  wire logic pri
);
  logic        sync_ff;
  logic        seen_ff;
  int unsigned hi_ff;
  int unsigned lo_ff;
  int unsigned len_ff;

  // Run lengths of the window and of the dead time
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_ff <= 1'b0;
      seen_ff <= 1'b0;
      hi_ff   <= 0;
      lo_ff   <= 0;
      len_ff  <= 0;
    end else begin
      sync_ff <= sync;
      seen_ff <= seen_ff | sync;
      hi_ff   <= sync ? hi_ff + 1 : 0;
      lo_ff   <= sync ? 0 : lo_ff + 1;
      // Packet length counted here; too long for a delay range
      len_ff  <= m_line_oe ? len_ff + 1 : 0;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  AST_WINDOW_LEN: assert property (sync_ff && !sync |-> hi_ff == CYCLE_CLKS - DEAD_CLKS)
    else $error("transfer window length wrong");
  AST_DEAD_LEN: assert property (seen_ff && !sync_ff && sync |-> lo_ff == DEAD_CLKS)
    else $error("dead time length wrong");
  AST_NO_CONTEND: assert property (!(m_line_oe && c_line_oe))
    else $error("both ends drive the line");
  AST_M_START: assert property ($rose(m_line_oe) |-> !m_line_o && sync)
    else $error("master packet without start bit or outside window");
  AST_C_START: assert property ($rose(c_line_oe) |-> !c_line_o)
    else $error("card packet without start bit");
  AST_M_STOP: assert property ($fell(m_line_oe) |-> $past(m_line_o))
    else $error("master packet not ended by stop bit");
  AST_M_LEN: assert property ($fell(m_line_oe) |-> len_ff >= 1240 && len_ff <= 1260)
    else $error("master packet length wrong");
  AST_PRI_LOW: assert property (c_pri_oe |-> !c_pri_o)
    else $error("priority wire driven high");
  AST_CARD_WIN: assert property (c_line_oe && !c_pri_oe |-> sync)
    else $error("card sends outside transfer window");
endmodule

// [dv/test_serial_net_interface_card.sv]
// Purpose: Self-checking bench for card and poll master facing each other.
// Assumes: Shortened frame counts; APB driven at rising edges.
// Notes:   Flags sampled at falling edges; APB answers at the rising edge.
`timescale 1ns/10ps
module test_serial_net_interface_card;
  localparam int unsigned CYC = 8000;
  localparam int unsigned DEAD = 1000;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} snic_row_s;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        link_up = 1'b1;
  logic        down = 1'b1;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_sig = 8'h00;
  logic [7:0]  tx_data = 8'h00;
  logic        pready, pslverr, frame_tick, relay, autopoll, tx_ready, rx_valid;
  logic [31:0] prdata;
  logic [7:0]  rx_sig, rx_data;
  int          err_total = 0;
  int          check_count = 0;
  snic_if      net_bus ();
  wire  [4:0]  mon = {autopoll, frame_tick, rx_valid, tx_ready, net_bus.sync};
  snic_row_s   rows [0:8] = '{
    '{1'b0, 12'h00C, 32'h0, 32'h1, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h008, 32'h5A, 32'h0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h5A, 1'b0},
    '{1'b1, 12'h100, 32'h1122, 32'h0, 1'b0},
    '{1'b0, 12'h100, 32'h0, 32'h1122, 1'b0},
    '{1'b1, 12'h200, 32'h133, 32'h0, 1'b0},
    '{1'b0, 12'h300, 32'h0, 32'h0, 1'b1},
    '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}};

  always #4 i_sys_clk = ~i_sys_clk;

  snic_card #(.CYCLE_CLKS(CYC), .DEAD_CLKS(DEAD), .WDOG_CLKS(16000)) snic_card_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_frame_tick(frame_tick),
    .o_relay_close(relay), .o_autopoll(autopoll), .net(net_bus));
  snic_poll_master #(.CYCLE_CLKS(CYC), .DEAD_CLKS(DEAD)) snic_poll_master_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_link_up(link_up),
    .i_downstream_present(down), .i_tx_valid(tx_valid), .i_tx_sig(tx_sig),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_sig(rx_sig),
    .o_rx_data(rx_data), .o_in_transfer(), .net(net_bus));
  snic_checker #(.CYCLE_CLKS(CYC), .DEAD_CLKS(DEAD)) snic_checker_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .sync(net_bus.sync),
    .downstream(net_bus.downstream), .m_line_o(net_bus.m_line_o),
    .m_line_oe(net_bus.m_line_oe), .c_line_o(net_bus.c_line_o),
    .c_line_oe(net_bus.c_line_oe), .c_pri_o(net_bus.c_pri_o), .c_pri_oe(net_bus.c_pri_oe),
    .line(net_bus.line), .pri(net_bus.pri));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for one monitored flag; a timeout counts as a mismatch
  task automatic till(input int b, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (mon[b] !== v && n < lim);
    chk("wait flag", {31'h0, mon[b]}, {31'h0, v});
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // Ready, data and error taken at the completing rising edge
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic [7:0] s, input logic [7:0] d);
    int n;
    @(posedge i_sys_clk);
    tx_valid <= 1'b1;
    tx_sig <= s;
    tx_data <= d;
    till(1, 1'b1, 3000, n);
    @(posedge i_sys_clk);
    tx_valid <= 1'b0;
  endtask

  initial begin
    repeat (70000) @(posedge i_sys_clk);
    err_total++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    int          n;
    repeat (8) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    // Packet RAM is not reset: clear transmit words 1 to 15 so no stray words go out
    for (int i = 1; i < 16; i++) begin
      apb(1'b1, 12'h100 + 12'(4 * i), 32'h0, q, e);
    end
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, q, e);
      chk("slverr", {31'h0, e}, {31'h0, rows[i].e});
      if (!rows[i].w) chk("rdata", q, rows[i].x);
    end
    till(0, 1'b1, 9000, n);
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk("ram in window", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h000, 32'h1, q, e);
    send(8'h5A, 8'h00);
    till(2, 1'b1, 4000, n);
    chk("reply sig", {24'h0, rx_sig}, 32'h11);
    chk("reply data", {24'h0, rx_data}, 32'h22);
    // Let the card finish its stop bit before the master sends again
    repeat (100) @(posedge i_sys_clk);
    send(8'h33, 8'h44);
    send(8'h34, 8'h55);
    till(0, 1'b0, 9000, n);
    apb(1'b1, 12'h000, 32'h0, q, e);
    apb(1'b0, 12'h140, 32'h0, q, e);
    chk("rx word", q, 32'h3344);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("rx count", {27'h0, q[12:8]}, 32'h1);
    apb(1'b1, 12'h000, 32'h1, q, e);
    apb(1'b0, 12'h140, 32'h0, q, e);
    chk("ram while chip owns", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h000, 32'h2, q, e);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("count after chip reset", {27'h0, q[12:8]}, 32'h0);
    apb(1'b1, 12'h000, 32'h0, q, e);
    till(3, 1'b1, 9000, n);
    till(0, 1'b1, 2000, n);
    chk("tick to sync", {31'h0, n >= DEAD - 2 && n <= DEAD + 2}, 32'h1);
    @(posedge i_sys_clk);
    down <= 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk("relay closed", {31'h0, relay}, 32'h1);
    @(posedge i_sys_clk);
    down <= 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk("relay open", {31'h0, relay}, 32'h0);
    // Link dropped in dead time so no window is cut short
    till(0, 1'b0, 9000, n);
    @(posedge i_sys_clk);
    link_up <= 1'b0;
    till(4, 1'b1, 20000, n);
    chk("autopoll delay", {31'h0, n >= 7000}, 32'h1);
    // Link down, lock cleared: frame keeps its own period with no sync
    apb(1'b1, 12'h00C, 32'h0, q, e);
    till(3, 1'b1, 9000, n);
    till(3, 1'b1, 9000, n);
    chk("free-run frame", n, CYC);
    // System reset in mid-run restores the defaults
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(negedge i_sys_clk);
    chk("autopoll after reset", {31'h0, autopoll}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("lock after reset", q, 32'h1);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk("ident after reset", q, 32'h0);
    conclude();
  end
endmodule
